// File: src/spr_cfg.svh
`ifndef SPR_CFG_SVH
`define SPR_CFG_SVH

// Register file locations
`define SPR_ADDR_TDCP    8'hF2
`define SPR_ADDR_TDAP    8'hF3
`define SPR_ADDR_VEC     8'hF4
`define SPR_ADDR_ACMP    8'hF5
`define SPR_ADDR_MASK    8'hF6
`define SPR_ADDR_FLAGS   8'hF7
`define SPR_ADDR_DATA    8'hF8

// Mask register fields
`define SPR_M_BSN        7
`define SPR_M_RX_BLOCK_END_FLAG      6
`define SPR_M_TX_BLOCK_END_FLAG      5
`define SPR_M_RXE        4
`define SPR_M_RXA        3
`define SPR_M_RXB        2
`define SPR_M_RX_DATA_GATE       1
`define SPR_M_TX_DATA_GATE       0

// Flag register fields
`define SPR_F_OVR        7
`define SPR_F_FRM        6
`define SPR_F_PAR        5
`define SPR_F_ADR        4
`define SPR_F_BRK        3
`define SPR_F_RXD        2
`define SPR_F_TXB        1
`define SPR_F_TXS        0

// Reset values
`define SPR_RST_ZERO     8'h00
`define SPR_RST_ONES     8'hFF

// Encoded interrupt sources
`define SPR_EV_ERR       2'h0
`define SPR_EV_BRKADR    2'h1
`define SPR_EV_RXDATA    2'h2
`define SPR_EV_TXEMPTY   2'h3

`endif

// File: src/spr_pkg.sv
package spr_pkg;

	// Received character from the shift engine
	typedef struct packed {
		logic [7:0] data;
		logic [1:0] len;
		logic       ninth;
		logic       framing;
		logic       parity;
	} spr_rx_word_t;

	// Register file access
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} spr_reg_req_t;

	// Address scheme as {enable, select}
	typedef enum logic [1:0] {
		SPR_AM_NINTH,
		SPR_AM_SEARCH,
		SPR_AM_MATCH_NINTH,
		SPR_AM_AFTER_BREAK
	} spr_addr_mode_t;

endpackage : spr_pkg

// File: src/spr_regs.sv
`timescale 1ns/1ps
`include "spr_cfg.svh"

// What this block does
// - Tx counter pointer: bits 7:1 counter location, bit 0 source space
// - Tx address pointer: bits 7:1 pointer location, bit 0 extension select
// - Vector bits 7:3 are software base shared by transmit and receive
// - Vector bits 2:1 encode the source by hardware; bit 0 reads zero
// - In addressed modes a received address equal to compare sets address flag
// - After address flag set, following data items pass to receive holding
// - Mask bit 7 picks shift-empty or holding-empty as transmit source
// - Receive block end sets mask bit 6; software writes 0 to clear
// - Transmit block end sets mask bit 5; software writes 0 to clear
// - Mask bit 4 gates overrun, framing and parity interrupts
// - Mask bit 3 gates address interrupt, bit 2 gates break interrupt
// - Mask bit 1 gates received data and receive block end interrupts
// - Mask bit 0 gates transmit empty and transmit block end interrupts
// - Flag 7 set when a character overwrites an unread one
// - Flag 6 on missing stop bit; in address mode character still loads
// - Flag 5 on parity mismatch
// - Flag 4 on address-mode interrupt per two configuration bits
// - Flag 3 on break for a full character time
// - Flag 2 data loaded, flag 1 holding empty, flag 0 shift empty
// - Software writes only clear flags, never set them
// - Received data moves at character end; short formats pad ones
// - Data location reads receive holding, writes transmit holding
// - DMA enables clear themselves when the transaction counter ends
// - With DMA active, data and shift-empty sources become block-end sources
module spr_regs #(
	parameter int BUF_DEPTH = 2
) (
	// Clock and reset
	input  wire logic                  mclk_in,
	input  wire logic                  rst_b_in,
	// Core register file access
	input  wire spr_pkg::spr_reg_req_t reg_req_in,
	output logic [7:0]                 reg_rdata_out,
	// Receive shift engine events
	input  wire logic                  rx_word_valid_in,
	input  wire spr_pkg::spr_rx_word_t rx_word_in,
	input  wire logic                  rx_break_in,
	// Transmit shift engine
	input  wire logic                  tx_holding_empty_in,
	input  wire logic                  tx_shift_empty_in,
	output logic                       tx_valid_out,
	output logic [7:0]                 tx_data_out,
	input  wire logic                  tx_ready_in,
	output logic                       tx_write_ready_out,
	// Mode configuration
	input  wire logic                  address_scheme_enable_in,
	input  wire logic                  address_scheme_select_in,
	// DMA controller
	input  wire logic                  rx_dma_enable_in,
	input  wire logic                  tx_dma_enable_in,
	input  wire logic                  rx_dma_last_in,
	input  wire logic                  tx_dma_last_in,
	output logic                       rx_dma_enable_clear_out,
	output logic                       tx_dma_enable_clear_out,
	output logic                       rx_dma_request_out,
	// Interrupt request lines
	output logic                       irq_error_out,
	output logic                       irq_brk_addr_out,
	output logic                       irq_rx_out,
	output logic                       irq_tx_out
);
	import spr_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] tx_dma_counter_pointer;
	logic [7:0] tx_dma_address_pointer;
	logic [4:0] serial_vector_base;
	logic [7:0] address_compare_char;
	logic [7:0] serial_interrupt_mask;
	logic [7:0] serial_interrupt_flags;
	logic [7:0] receive_holding;
	logic       rx_unread;
	logic       addr_open;
	logic       after_break;

	// Synchronised pin-side levels
	logic [1:0] brk_sync;
	logic [1:0] hold_sync;
	logic [1:0] shift_sync;
	logic       brk_seen;
	logic       hold_seen;
	logic       shift_seen;

	// ****************************************
	// Decode
	// ****************************************
	wire wr_tdcp  = reg_req_in.wr && reg_req_in.addr == `SPR_ADDR_TDCP;
	wire wr_tdap  = reg_req_in.wr && reg_req_in.addr == `SPR_ADDR_TDAP;
	wire wr_vec   = reg_req_in.wr && reg_req_in.addr == `SPR_ADDR_VEC;
	wire wr_acmp  = reg_req_in.wr && reg_req_in.addr == `SPR_ADDR_ACMP;
	wire wr_mask  = reg_req_in.wr && reg_req_in.addr == `SPR_ADDR_MASK;
	wire wr_flags = reg_req_in.wr && reg_req_in.addr == `SPR_ADDR_FLAGS;
	wire wr_data  = reg_req_in.wr && reg_req_in.addr == `SPR_ADDR_DATA;
	wire rd_data  = reg_req_in.rd && reg_req_in.addr == `SPR_ADDR_DATA;

	// Pointer fields are split out here but drive no output of this block
	wire [6:0] tx_counter_location    = tx_dma_counter_pointer[7:1];
	wire       tx_source_space_select = tx_dma_counter_pointer[0];
	wire [6:0] tx_pointer_location    = tx_dma_address_pointer[7:1];
	// Extension select only counts when memory is the source
	wire       tx_extension_select    = tx_dma_address_pointer[0] & ~tx_source_space_select;

	// ****************************************
	// Receive path
	// ****************************************
	spr_addr_mode_t amode;
	assign amode = spr_addr_mode_t'({address_scheme_enable_in, address_scheme_select_in});

	// Only the enabled schemes hold data back until an address matches
	wire addressed   = address_scheme_enable_in;
	wire cmp_hit     = rx_word_in.data == address_compare_char;
	wire is_addr_word;
	wire addr_hit;
	assign is_addr_word = (amode == SPR_AM_NINTH || amode == SPR_AM_MATCH_NINTH) ?
		rx_word_in.ninth : (amode == SPR_AM_AFTER_BREAK) ? after_break : 1'b0;
	// Address flag condition per configured scheme
	assign addr_hit = (amode == SPR_AM_NINTH)       ? rx_word_in.ninth :
	                  (amode == SPR_AM_SEARCH)      ? cmp_hit :
	                  (amode == SPR_AM_MATCH_NINTH) ? rx_word_in.ninth & cmp_hit :
	                                                   after_break & cmp_hit;

	wire set_adr = rx_word_valid_in && addr_hit;
	// Address words stay out of the holding register; a framing error still loads
	wire load_rx = rx_word_valid_in && !set_adr &&
		(!addressed || addr_open || rx_word_in.framing) &&
		!(addressed && is_addr_word && !rx_word_in.framing);

	// Short formats pad unused upper bits with ones
	wire [7:0] pad_mask = `SPR_RST_ONES << ({1'b0, rx_word_in.len} + 4'd5);
	wire [7:0] rx_padded = rx_word_in.data | pad_mask;

	wire set_ovr = load_rx && rx_unread;
	wire set_frm = rx_word_valid_in && rx_word_in.framing;
	wire set_par = rx_word_valid_in && rx_word_in.parity;
	wire set_brk = brk_sync[1] && !brk_seen;
	wire set_txb = hold_sync[1] && !hold_seen;
	wire set_txs = shift_sync[1] && !shift_seen;

	// ****************************************
	// Flag register update
	// ****************************************
	wire [7:0] hw_set = {set_ovr, set_frm, set_par, set_adr, set_brk, load_rx, set_txb, set_txs};
	wire [7:0] sw_keep = wr_flags ? reg_req_in.wdata : `SPR_RST_ONES;
	wire [7:0] next_flags = (serial_interrupt_flags & sw_keep) | hw_set;

	// Block-end flags: software may write 0 only; hardware set wins
	wire [1:0] eob_set = {rx_dma_last_in, tx_dma_last_in};
	wire [1:0] eob_keep = wr_mask ? reg_req_in.wdata[6:5] : 2'b11;
	wire [1:0] next_eob = (serial_interrupt_mask[6:5] & eob_keep) | eob_set;

	// ****************************************
	// Interrupt requests
	// ****************************************
	wire [7:0] m = serial_interrupt_mask;
	wire [7:0] f = serial_interrupt_flags;
	wire err_req = m[`SPR_M_RXE] & (f[`SPR_F_OVR] | f[`SPR_F_FRM] | f[`SPR_F_PAR]);
	wire adr_req = m[`SPR_M_RXA] & f[`SPR_F_ADR];
	wire brk_req = m[`SPR_M_RXB] & f[`SPR_F_BRK];
	// DMA swaps data pending for receive block end
	wire rx_src  = rx_dma_enable_in ? m[`SPR_M_RX_BLOCK_END_FLAG] : f[`SPR_F_RXD];
	wire rx_req  = m[`SPR_M_RX_DATA_GATE] & rx_src;
	wire tx_empty = m[`SPR_M_BSN] ? f[`SPR_F_TXB] : f[`SPR_F_TXS];
	wire tx_src  = tx_dma_enable_in ? (m[`SPR_M_TX_BLOCK_END_FLAG] | (m[`SPR_M_BSN] & f[`SPR_F_TXB]))
	                                : tx_empty;
	wire tx_req  = m[`SPR_M_TX_DATA_GATE] & tx_src;

	// Fixed internal priority picks the encoded source
	wire [1:0] enc_src = err_req ? `SPR_EV_ERR :
	                     (brk_req | adr_req) ? `SPR_EV_BRKADR :
	                     rx_req ? `SPR_EV_RXDATA : `SPR_EV_TXEMPTY;

	assign irq_error_out    = err_req;
	assign irq_brk_addr_out = brk_req | adr_req;
	assign irq_rx_out       = rx_req;
	assign irq_tx_out       = tx_req;
	// Data mask does not affect DMA requests
	assign rx_dma_request_out = rx_dma_enable_in & f[`SPR_F_RXD];
	// DMA enables drop when the counter runs out
	assign rx_dma_enable_clear_out = rx_dma_last_in;
	assign tx_dma_enable_clear_out = tx_dma_last_in;

	// ****************************************
	// Transmit holding buffer
	// ****************************************
	// Two entries hold written bytes while the shift engine stalls; a write to a full buffer is dropped
	logic [7:0] tx_mem [BUF_DEPTH];
	logic [$clog2(BUF_DEPTH):0] tx_count;
	logic [$clog2(BUF_DEPTH)-1:0] tx_rd_ptr;
	logic [$clog2(BUF_DEPTH)-1:0] tx_wr_ptr;
	wire tx_full  = tx_count == ($clog2(BUF_DEPTH)+1)'(BUF_DEPTH);
	wire tx_push  = wr_data && !tx_full;
	wire tx_pop   = tx_valid_out && tx_ready_in;
	assign tx_valid_out       = tx_count != '0;
	assign tx_write_ready_out = !tx_full;

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tx_count  <= '0;
			tx_rd_ptr <= '0;
			tx_wr_ptr <= '0;
			tx_data_out <= `SPR_RST_ZERO;
		end else begin
			tx_count  <= tx_count + (($clog2(BUF_DEPTH)+1)'(tx_push))
			             - (($clog2(BUF_DEPTH)+1)'(tx_pop));
			if (tx_push) tx_wr_ptr <= tx_wr_ptr + 1'b1;
			if (tx_pop) tx_rd_ptr <= tx_rd_ptr + 1'b1;
			tx_data_out <= (tx_pop || tx_count == '0) ?
				(tx_count > 1 ? tx_mem[tx_rd_ptr + 1'b1] : reg_req_in.wdata) :
				tx_mem[tx_rd_ptr];
		end
	end

	generate
		for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_txmem
			always_ff @(posedge mclk_in or negedge rst_b_in) begin
				if (!rst_b_in) tx_mem[i] <= `SPR_RST_ZERO;
				else if (tx_push && tx_wr_ptr == i) tx_mem[i] <= reg_req_in.wdata;
			end
		end
	endgenerate

	// ****************************************
	// Register state
	// ****************************************
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			brk_sync   <= 2'b00;
			hold_sync  <= 2'b00;
			shift_sync <= 2'b00;
			brk_seen   <= 1'b0;
			hold_seen  <= 1'b0;
			shift_seen <= 1'b0;
		end else begin
			brk_sync   <= {brk_sync[0], rx_break_in};
			hold_sync  <= {hold_sync[0], tx_holding_empty_in};
			shift_sync <= {shift_sync[0], tx_shift_empty_in};
			brk_seen   <= brk_sync[1];
			hold_seen  <= hold_sync[1];
			shift_seen <= shift_sync[1];
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tx_dma_counter_pointer <= `SPR_RST_ZERO;
			tx_dma_address_pointer <= `SPR_RST_ZERO;
			serial_vector_base     <= 5'h0_0;
			address_compare_char   <= `SPR_RST_ZERO;
		end else begin
			if (wr_tdcp) tx_dma_counter_pointer <= reg_req_in.wdata;
			if (wr_tdap) tx_dma_address_pointer <= reg_req_in.wdata;
			if (wr_vec) serial_vector_base <= reg_req_in.wdata[7:3];
			if (wr_acmp) address_compare_char <= reg_req_in.wdata;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			serial_interrupt_mask  <= `SPR_RST_ZERO;
			serial_interrupt_flags <= `SPR_RST_ZERO;
		end else begin
			serial_interrupt_mask <= {wr_mask ? reg_req_in.wdata[7] : m[7], next_eob,
			                          wr_mask ? reg_req_in.wdata[4:0] : m[4:0]};
			serial_interrupt_flags <= next_flags;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			receive_holding <= `SPR_RST_ONES;
			rx_unread       <= 1'b0;
			addr_open       <= 1'b0;
			after_break     <= 1'b0;
		end else begin
			if (load_rx) receive_holding <= rx_padded;
			rx_unread <= load_rx | (rx_unread & ~rd_data);
			// A matched address opens the gate; an unmatched address word shuts it
			if (rx_word_valid_in && is_addr_word) addr_open <= set_adr;
			if (set_brk) after_break <= 1'b1;
			else if (rx_word_valid_in) after_break <= 1'b0;
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	always_comb begin
		case (reg_req_in.addr)
			`SPR_ADDR_TDCP:  reg_rdata_out = tx_dma_counter_pointer;
			`SPR_ADDR_TDAP:  reg_rdata_out = tx_dma_address_pointer;
			`SPR_ADDR_VEC:   reg_rdata_out = {serial_vector_base, enc_src, 1'b0};
			`SPR_ADDR_ACMP:  reg_rdata_out = address_compare_char;
			`SPR_ADDR_MASK:  reg_rdata_out = serial_interrupt_mask;
			`SPR_ADDR_FLAGS: reg_rdata_out = serial_interrupt_flags;
			`SPR_ADDR_DATA:  reg_rdata_out = receive_holding;
			default:         reg_rdata_out = `SPR_RST_ZERO;
		endcase
	end

	// ****************************************
	// Checks
	// ****************************************
	a_flag_sw_noset: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(wr_flags && hw_set == 8'h00) |=> ((serial_interrupt_flags & ~$past(serial_interrupt_flags))
		== 8'h00)) else $error("software write set a flag");
	a_set_wins: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		rx_word_valid_in && rx_word_in.parity |=> f[`SPR_F_PAR]) else $error("parity set lost");
	a_overrun_set: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(load_rx && rx_unread) |=> f[`SPR_F_OVR]) else $error("overrun not flagged");
	a_data_pad: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(load_rx && rx_word_in.len == 2'b00) |=> receive_holding[7:5] == 3'b111)
		else $error("short data not padded");
	a_vec_zero: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		reg_req_in.addr == `SPR_ADDR_VEC |-> reg_rdata_out[0] == 1'b0) else $error("vector bit 0 set");
	a_err_gate: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		!m[`SPR_M_RXE] |-> !irq_error_out) else $error("error irq while masked");
	a_eob_sets: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		tx_dma_last_in |=> m[`SPR_M_TX_BLOCK_END_FLAG]) else $error("tx block end not set");
	a_addr_drop: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		set_adr |-> !load_rx ##1 f[`SPR_F_ADR]) else $error("address word loaded");

	// Gating, sources, block ends, flag setting, loading, buffer drop and clearing
	a_rx_eob_set: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		rx_dma_last_in |=> m[`SPR_M_RX_BLOCK_END_FLAG]) else $error("rx block end not set");
	a_brk_adr_gate: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(!m[`SPR_M_RXB] && !m[`SPR_M_RXA]) |-> !irq_brk_addr_out)
		else $error("break or address irq while masked");
	a_rx_gate: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		!m[`SPR_M_RX_DATA_GATE] |-> !irq_rx_out) else $error("receive irq while masked");
	a_tx_gate: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		!m[`SPR_M_TX_DATA_GATE] |-> !irq_tx_out) else $error("transmit irq while masked");
	a_tx_src_sel: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(m[`SPR_M_TX_DATA_GATE] && !tx_dma_enable_in && m[`SPR_M_BSN]) |-> irq_tx_out == f[`SPR_F_TXB])
		else $error("holding empty source not selected");
	a_frm_set: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(rx_word_valid_in && rx_word_in.framing) |=> f[`SPR_F_FRM]) else $error("framing not flagged");
	a_brk_set: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		set_brk |=> f[`SPR_F_BRK]) else $error("break not flagged");
	a_rx_load: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		load_rx |=> f[`SPR_F_RXD] && receive_holding == $past(rx_padded))
		else $error("received word not loaded");
	a_full_drop: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(wr_data && tx_full && !tx_pop) |=> tx_count == $past(tx_count))
		else $error("write to full buffer stored");
	a_dma_clear: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		rx_dma_last_in |-> rx_dma_enable_clear_out) else $error("rx dma enable not cleared");
	a_rx_dma_swap: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(rx_dma_enable_in && m[`SPR_M_RX_DATA_GATE] && !m[`SPR_M_RX_BLOCK_END_FLAG]) |-> !irq_rx_out)
		else $error("data pending irq during dma");
	a_tx_dma_swap: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(tx_dma_enable_in && m[`SPR_M_TX_DATA_GATE] && !m[`SPR_M_TX_BLOCK_END_FLAG] && !m[`SPR_M_BSN]) |-> !irq_tx_out)
		else $error("shift empty irq during dma");
	a_addr_open: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(rx_word_valid_in && addressed && addr_open && !is_addr_word && !set_adr) |-> load_rx)
		else $error("data after address dropped");
	a_vec_err: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(reg_req_in.addr == `SPR_ADDR_VEC && err_req) |-> reg_rdata_out[2:1] == `SPR_EV_ERR)
		else $error("error source not encoded");
	a_sw_clear: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(wr_flags && reg_req_in.wdata == 8'h00 && hw_set == 8'h00) |=> f == 8'h00)
		else $error("flags not cleared by write");

endmodule : spr_regs

// File: verif/spr_tx_sink.sv
`timescale 1ns/1ps

// ****************************************
// Transmit consumer standing in for the shift engine
// ****************************************
module spr_tx_sink (
	// Clock and reset
	input  wire logic       mclk_in,
	input  wire logic       rst_b_in,
	// Stall request from the bench
	input  wire logic       stall_in,
	// Buffer side
	input  wire logic       tx_valid_in,
	input  wire logic [7:0] tx_data_in,
	output logic            tx_ready_out,
	// Observation
	output logic [7:0]      first_out,
	output logic [7:0]      last_out,
	output logic [7:0]      count_out
);
	// Ready drops while stalled so the buffer must hold its words
	assign tx_ready_out = !stall_in;

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			first_out <= 8'h00;
			last_out  <= 8'h00;
			count_out <= 8'h00;
		end else if (tx_valid_in && tx_ready_out) begin
			if (count_out == 8'h00) begin
				first_out <= tx_data_in;
			end
			last_out  <= tx_data_in;
			count_out <= count_out + 8'h01;
		end
	end
endmodule : spr_tx_sink

// File: verif/tb.sv
`timescale 1ns/1ps

module tb;
	import spr_pkg::*;
	logic         mclk_in, rst_b_in, rx_v, brk, hemp, semp, tx_valid, tx_ready, wr_rdy;
	logic         am_en, am_sel, rde, tde, rlast, tlast, rclr, tclr, rreq, stall;
	logic         i_err, i_ba, i_rx, i_tx;
	logic [7:0]   rdata, tx_data, first_w, last_w, n_taken, v;
	spr_reg_req_t req;
	spr_rx_word_t rxw_d;
	int           failures, n_tests, cycles;

	spr_regs spr_regs_i (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_req_in(req),
		.reg_rdata_out(rdata), .rx_word_valid_in(rx_v), .rx_word_in(rxw_d),
		.rx_break_in(brk), .tx_holding_empty_in(hemp), .tx_shift_empty_in(semp),
		.tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_ready_in(tx_ready),
		.tx_write_ready_out(wr_rdy), .address_scheme_enable_in(am_en),
		.address_scheme_select_in(am_sel), .rx_dma_enable_in(rde), .tx_dma_enable_in(tde),
		.rx_dma_last_in(rlast), .tx_dma_last_in(tlast), .rx_dma_enable_clear_out(rclr),
		.tx_dma_enable_clear_out(tclr), .rx_dma_request_out(rreq), .irq_error_out(i_err),
		.irq_brk_addr_out(i_ba), .irq_rx_out(i_rx), .irq_tx_out(i_tx));

	spr_tx_sink spr_tx_sink_i (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .stall_in(stall),
		.tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_ready_out(tx_ready),
		.first_out(first_w), .last_out(last_w), .count_out(n_taken));

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk_in);
		req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_in);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(negedge mclk_in);
		d = rdata;
		@(posedge mclk_in);
		req.rd <= 1'b0;
	endtask : rd

	task automatic rc(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(what, d, exp);
	endtask : rc

	// Interrupt lines as {error, break/address, receive, transmit}
	task automatic ic(input logic [3:0] exp);
		@(negedge mclk_in);
		chk("irq", {4'h0, i_err, i_ba, i_rx, i_tx}, {4'h0, exp});
	endtask : ic

	task automatic rx(input logic [7:0] d, input logic [1:0] len, input logic nin, fr, par);
		@(posedge mclk_in);
		rx_v  <= 1'b1;
		rxw_d <= '{data: d, len: len, ninth: nin, framing: fr, parity: par};
		@(posedge mclk_in);
		rx_v  <= 1'b0;
	endtask : rx

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	// ****************************************
	// Clock, watchdog and test sequence
	// ****************************************
	initial begin
		mclk_in = 1'b0;
		forever #4 mclk_in = ~mclk_in;
	end

	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			final_report();
		end
	end

	initial begin
		{rst_b_in, rx_v, brk, hemp, semp, am_en, am_sel, rde, tde, rlast, tlast, stall} = '0;
		req   = '0;
		rxw_d = '0;
		repeat (2) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		for (int a = 2; a < 8; a++) begin
			rd(8'hF0 + 8'(a), v);
			chk("reset value", v & ((a == 4) ? 8'hF9 : 8'hFF), 8'h00);
		end
		rc("holding reset", 8'hF8, 8'hFF);
		wr(8'hF2, 8'hA5);
		rc("counter pointer", 8'hF2, 8'hA5);
		wr(8'hF3, 8'h5A);
		rc("address pointer", 8'hF3, 8'h5A);
		wr(8'hF4, 8'hFF);
		rd(8'hF4, v);
		chk("vector base", v & 8'hF9, 8'hF8);
		$display("test registers done");
		wr(8'hF6, 8'h02);
		rx(8'h41, 2'b11, 1'b0, 1'b0, 1'b0);
		rc("holding", 8'hF8, 8'h41);
		rc("flags", 8'hF7, 8'h04);
		ic(4'b0010);
		rc("vector", 8'hF4, 8'hFC);
		rx(8'h05, 2'b00, 1'b0, 1'b0, 1'b0);
		rc("short holding", 8'hF8, 8'hE5);
		rx(8'h66, 2'b01, 1'b0, 1'b0, 1'b0);
		rx(8'h12, 2'b11, 1'b0, 1'b0, 1'b0);
		rc("overrun", 8'hF7, 8'h84);
		wr(8'hF7, 8'h7F);
		rc("clear one", 8'hF7, 8'h04);
		wr(8'hF7, 8'hFF);
		rc("no set", 8'hF7, 8'h04);
		rc("overrun holding", 8'hF8, 8'h12);
		wr(8'hF7, 8'h00);
		wr(8'hF6, 8'h10);
		rx(8'h21, 2'b11, 1'b0, 1'b1, 1'b0);
		rc("framing", 8'hF7, 8'h44);
		ic(4'b1000);
		rc("vector error", 8'hF4, 8'hF8);
		rc("framed char", 8'hF8, 8'h21);
		wr(8'hF7, 8'h00);
		rx(8'h22, 2'b11, 1'b0, 1'b0, 1'b1);
		rc("parity", 8'hF7, 8'h24);
		wr(8'hF6, 8'h00);
		ic(4'b0000);
		wr(8'hF7, 8'h00);
		$display("test receive done");
		wr(8'hF6, 8'h04);
		brk <= 1'b1;
		repeat (6) @(posedge mclk_in);
		rc("break", 8'hF7, 8'h08);
		ic(4'b0100);
		rc("vector break", 8'hF4, 8'hFA);
		brk <= 1'b0;
		wr(8'hF6, 8'h00);
		ic(4'b0000);
		wr(8'hF7, 8'h00);
		hemp <= 1'b1;
		repeat (6) @(posedge mclk_in);
		rc("holding empty", 8'hF7, 8'h02);
		wr(8'hF6, 8'h01);
		ic(4'b0000);
		wr(8'hF6, 8'h81);
		ic(4'b0001);
		rc("vector tx", 8'hF4, 8'hFE);
		semp <= 1'b1;
		repeat (6) @(posedge mclk_in);
		rc("shift empty", 8'hF7, 8'h03);
		wr(8'hF6, 8'h01);
		ic(4'b0001);
		wr(8'hF6, 8'h00);
		ic(4'b0000);
		wr(8'hF7, 8'h00);
		{hemp, semp} <= 2'b00;
		$display("test events done");
		tde <= 1'b1;
		@(posedge mclk_in);
		tlast <= 1'b1;
		@(negedge mclk_in);
		chk("tx enable clear", {7'h00, tclr}, 8'h01);
		@(posedge mclk_in);
		tlast <= 1'b0;
		rc("tx block end", 8'hF6, 8'h20);
		wr(8'hF6, 8'h21);
		ic(4'b0001);
		wr(8'hF6, 8'h01);
		rc("tx end cleared", 8'hF6, 8'h01);
		wr(8'hF6, 8'h21);
		rc("tx end no set", 8'hF6, 8'h01);
		tde  <= 1'b0;
		rde  <= 1'b1;
		@(posedge mclk_in);
		rlast <= 1'b1;
		@(negedge mclk_in);
		chk("rx enable clear", {7'h00, rclr}, 8'h01);
		@(posedge mclk_in);
		rlast <= 1'b0;
		rc("rx block end", 8'hF6, 8'h41);
		wr(8'hF6, 8'h42);
		ic(4'b0010);
		wr(8'hF6, 8'h02);
		rc("rx end cleared", 8'hF6, 8'h02);
		rx(8'h55, 2'b11, 1'b0, 1'b0, 1'b0);
		ic(4'b0000);
		chk("dma request", {7'h00, rreq}, 8'h01);
		rde <= 1'b0;
		wr(8'hF6, 8'h00);
		rd(8'hF8, v);
		wr(8'hF7, 8'h00);
		$display("test dma done");
		stall <= 1'b1;
		wr(8'hF8, 8'hAA);
		wr(8'hF8, 8'hBB);
		@(negedge mclk_in);
		chk("buffer full", {7'h00, wr_rdy}, 8'h00);
		wr(8'hF8, 8'hCC);
		stall <= 1'b0;
		repeat (5) @(posedge mclk_in);
		chk("words taken", n_taken, 8'h02);
		chk("first word", first_w, 8'hAA);
		chk("last word", last_w, 8'hBB);
		$display("test transmit done");
		wr(8'hF5, 8'h5C);
		{am_en, am_sel} <= 2'b10;
		wr(8'hF6, 8'h08);
		rx(8'h5C, 2'b11, 1'b1, 1'b0, 1'b0);
		rc("address hit", 8'hF7, 8'h10);
		ic(4'b0100);
		wr(8'hF7, 8'h00);
		rx(8'h33, 2'b11, 1'b0, 1'b0, 1'b0);
		rc("addressed data", 8'hF8, 8'h33);
		{am_en, am_sel} <= 2'b01;
		wr(8'hF7, 8'h00);
		rx(8'h5C, 2'b11, 1'b0, 1'b0, 1'b0);
		rd(8'hF7, v);
		chk("char search", v & 8'h10, 8'h10);
		$display("test address done");
		final_report();
	end
endmodule : tb
